//--- core/kms_key_buffer.sv
`timescale 1ns/1ps
module kms_key_buffer #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic [AW-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	// Registered read; a fresh write shows one edge later
	always_ff @(posedge clk) begin
		if (rst) begin
			rdData <= '0;
		end else begin
			rdData <= mem[rdAddr];
		end
	end

endmodule

//--- core/kms_key_matrix_scanner.sv
`timescale 1ns/1ps
`include "kms_cfg.svh"
// Contract
// - Column count programmable from one to twenty; only configured columns scanned.
// - Row count programmable from one to eight; up to 160 keys in sequence.
// - Detected key codes go into a sixteen-entry key-code buffer.
// - One key position per 128 kHz tick, plus three settle ticks per column; full matrix in about 1.7 ms.
// - Any number of keys reported; the later ghost-involved key locked out, earlier column keys reported.
// - Buffered entries stay until read by the host; new codes dropped while buffer full.
// - Row inputs debounced and glitch filtered before a key counts.
// - Clock request raised so the shared 128 kHz oscillator runs.
// - Disabled scanner keeps its clock request low always.
// - Request dropped with no keys pressed, raised again on a keypress.
// - Machine starts idle; idle drives every column output high.
// - Idle row transition raises clock request and enters scan.
// - Idle clears the row-hit register and key-index counter.
// - Row counter steps to count minus one, wraps, advances column.
// - Both counters terminal moves the machine to scan-end.
// - Key-index counter advances per scanned key position.
// - Key index checked against modifier codes; non-modifiers buffered.
// - Row-hit register ORs column rows when column has two or more hits.
// - Key on a row already set in the row-hit register sets ghost status bit.
// - Scan-end rescans if any key seen, else idle and drop request.
module kms_key_matrix_scanner
	import kms_pkg::*;
#(
	parameter int NUM_COLS = `KMS_MAX_COLS,
	parameter int NUM_ROWS = `KMS_MAX_ROWS,
	parameter int FIFO_DEPTH = `KMS_FIFO_DEPTH,
	parameter int TICK_CYC = `KMS_TICK_CYC,
	parameter int FILT_TAPS = `KMS_FILT_TAPS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NUM_ROWS-1:0] rowIn,
	output logic [NUM_COLS-1:0] colDrive,
	output logic clkReq
);

	localparam int AW = $clog2(FIFO_DEPTH);
	localparam int NKEYS = NUM_COLS * NUM_ROWS;
	localparam logic [NUM_ROWS-1:0] ROW_ONE = {{(NUM_ROWS-1){1'b0}}, 1'b1};
	localparam logic [NUM_COLS-1:0] COL_ONE = {{(NUM_COLS-1){1'b0}}, 1'b1};

	function automatic logic [4:0] clampCount(input logic [4:0] v, input logic [4:0] maxV);
		if (v == 5'h00) begin
			return 5'h01;
		end
		return (v > maxV) ? maxV : v;
	endfunction

	function automatic logic isMapped(input logic [7:0] a);
		return a == `KMS_OFS_CTRL || a == `KMS_OFS_STATUS || a == `KMS_OFS_KEYDATA ||
			a == `KMS_OFS_MODCODE || a == `KMS_OFS_MODSTATE || a == `KMS_OFS_DEBUG;
	endfunction

	function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [3:0] modMatch(input logic [31:0] codes, input logic [7:0] idx);
		logic [3:0] m;
		m = 4'h0;
		for (int i = 0; i < 4; i++) begin
			m[i] = codes[8*i +: 8] == idx;
		end
		return m;
	endfunction

	logic [NUM_ROWS-1:0] rowMeta_q;
	logic [NUM_ROWS-1:0] rowSync_q;
	logic [NUM_ROWS-1:0] rowPrev_q;
	logic [NUM_ROWS-1:0][FILT_TAPS-1:0] filt_q;
	logic [NUM_ROWS-1:0] rowFilt;
	logic [31:0] ctrl_q;
	logic [31:0] modCode_q;
	logic [3:0] modState_q;
	logic ghost_q;
	logic ovf_q;
	kms_state_type state_q;
	logic [15:0] tick_q;
	logic scanTick;
	logic [2:0] rowIdx_q;
	logic [4:0] colIdx_q;
	kms_key_idx_type keyIdx_q;
	logic [NUM_ROWS-1:0] rowHit_q;
	logic [NUM_ROWS-1:0] colHits_q;
	logic [NUM_ROWS-1:0] colHitsNext;
	logic [2:0] settle_q;
	logic anyKey_q;
	logic [NKEYS-1:0] keyMap_q;
	logic [NUM_COLS-1:0] colDrive_q;
	logic enable;
	logic [4:0] colCnt;
	logic [4:0] rowCnt;
	logic lastRow;
	logic lastCol;
	logic keyStep;
	logic hit;
	logic ghostHit;
	logic keyChange;
	logic multiHit;
	logic [3:0] modHits;
	logic push;
	logic pop;
	logic [8:0] pushData;
	logic [8:0] headData;
	logic [AW:0] wptr_q;
	logic [AW:0] wptrSeen_q;
	logic [AW:0] rptr_q;
	logic [AW:0] fill;
	logic [AW:0] avail;
	logic full;
	logic awHeld_q;
	logic wHeld_q;
	logic [7:0] awAddr_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic doWrite;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	logic [31:0] rdMux;
	logic arTake;

	assign enable = ctrl_q[`KMS_CTRL_EN_BIT];
	assign colCnt = clampCount(ctrl_q[`KMS_CTRL_COLS_LSB +: 5], 5'(NUM_COLS));
	assign rowCnt = clampCount({1'b0, ctrl_q[`KMS_CTRL_ROWS_LSB +: 4]}, 5'(NUM_ROWS));
	assign lastRow = rowIdx_q == 3'(rowCnt - 5'h01);
	assign lastCol = colIdx_q == (colCnt - 5'h01);

	always_ff @(posedge clk) begin
		if (rst) begin
			rowMeta_q <= '0;
			rowSync_q <= '0;
			rowPrev_q <= '0;
		end else begin
			rowMeta_q <= rowIn;
			rowSync_q <= rowMeta_q;
			rowPrev_q <= rowSync_q;
		end
	end

	// row must read high on every recent tick
	generate
		for (genvar g = 0; g < NUM_ROWS; g++) begin : g_filt
			always_ff @(posedge clk) begin
				if (rst) begin
					filt_q[g] <= '0;
				end else if (scanTick) begin
					filt_q[g] <= {filt_q[g][FILT_TAPS-2:0], rowSync_q[g]};
				end
			end
			assign rowFilt[g] = &filt_q[g];
		end
	endgenerate

	// request only while enabled and busy
	assign clkReq = enable && (state_q != KMS_IDLE);

	// Stands in for the gated 128 kHz clock; frozen while request is low
	// one key position per tick
	assign scanTick = clkReq && (tick_q == 16'(TICK_CYC - 1));
	always_ff @(posedge clk) begin
		if (rst || !clkReq || scanTick) begin
			tick_q <= '0;
		end else begin
			tick_q <= tick_q + 16'h0001;
		end
	end

	assign keyStep = (state_q == KMS_SCAN) && scanTick && (settle_q == 3'h0);
	assign hit = rowFilt[rowIdx_q];
	assign ghostHit = hit && rowHit_q[rowIdx_q];
	// ghost-involved keys cannot register a press; a release still passes
	assign keyChange = keyStep && (hit != keyMap_q[keyIdx_q]) && !ghostHit;
	assign modHits = modMatch(modCode_q, keyIdx_q);
	assign push = keyChange && (modHits == 4'h0);
	assign pushData = {~hit, keyIdx_q};
	assign colHitsNext = colHits_q | ({{(NUM_ROWS-1){1'b0}}, hit} << rowIdx_q);
	assign multiHit = (colHitsNext & (colHitsNext - ROW_ONE)) != '0;

	always_ff @(posedge clk) begin
		if (rst || !enable) begin
			state_q <= KMS_IDLE;
		end else begin
			case (state_q)
				KMS_IDLE: begin
					if (rowSync_q != rowPrev_q) begin
						state_q <= KMS_SCAN;
					end
				end
				KMS_SCAN: begin
					if (keyStep && lastRow && lastCol) begin
						state_q <= KMS_SCAN_END;
					end
				end
				KMS_SCAN_END: begin
					state_q <= anyKey_q ? KMS_SCAN : KMS_IDLE;
				end
				default: begin
					state_q <= KMS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst || state_q != KMS_SCAN) begin
			rowIdx_q <= '0;
			colIdx_q <= '0;
			keyIdx_q <= '0;
			colHits_q <= '0;
			settle_q <= 3'(FILT_TAPS);
		end else if (scanTick) begin
			if (settle_q != 3'h0) begin
				settle_q <= settle_q - 3'h1;
			end else begin
				keyIdx_q <= keyIdx_q + 8'h01;
				if (lastRow) begin
					rowIdx_q <= '0;
					colHits_q <= '0;
					settle_q <= 3'(FILT_TAPS);
					if (!lastCol) begin
						colIdx_q <= colIdx_q + 5'h01;
					end
				end else begin
					rowIdx_q <= rowIdx_q + 3'h1;
					colHits_q <= colHitsNext;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst || state_q != KMS_SCAN) begin
			rowHit_q <= '0;
		end else if (keyStep && lastRow && multiHit) begin
			rowHit_q <= rowHit_q | colHitsNext;
		end
	end

	// Scan-end reads this before it clears
	always_ff @(posedge clk) begin
		if (rst || state_q != KMS_SCAN) begin
			anyKey_q <= 1'b0;
		end else if (keyStep && hit) begin
			anyKey_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			keyMap_q <= '0;
		end else if (keyChange) begin
			keyMap_q[keyIdx_q] <= hit;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			modState_q <= 4'h0;
		end else if (keyChange) begin
			modState_q <= hit ? (modState_q | modHits) : (modState_q & ~modHits);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			colDrive_q <= '1;
		end else if (state_q == KMS_SCAN) begin
			colDrive_q <= COL_ONE << colIdx_q;
		end else begin
			colDrive_q <= '1;
		end
	end
	assign colDrive = colDrive_q;

	kms_key_buffer #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH)
	) u_buf (
		.clk(clk),
		.rst(rst),
		.wrEn(push && !full),
		.wrAddr(wptr_q[AW-1:0]),
		.wrData(pushData),
		.rdAddr(rptr_q[AW-1:0]),
		.rdData(headData)
	);

	assign fill = wptr_q - rptr_q;
	assign full = fill == (AW+1)'(FIFO_DEPTH);
	// Lagging pointer hides entries until the registered read shows them
	assign avail = wptrSeen_q - rptr_q;
	assign pop = arTake && (s_axi_araddr == `KMS_OFS_KEYDATA) && (avail != '0);

	always_ff @(posedge clk) begin
		if (rst) begin
			wptr_q <= '0;
			wptrSeen_q <= '0;
			rptr_q <= '0;
		end else begin
			wptrSeen_q <= wptr_q;
			if (push && !full) begin
				wptr_q <= wptr_q + 1'b1;
			end
			// entries leave only on host read
			if (pop) begin
				rptr_q <= rptr_q + 1'b1;
			end
		end
	end

	// ghost flag, set wins over clear
	always_ff @(posedge clk) begin
		if (rst) begin
			ghost_q <= 1'b0;
		end else if (keyStep && ghostHit) begin
			ghost_q <= 1'b1;
		end else if (doWrite && awAddr_q == `KMS_OFS_STATUS && wStrb_q[0] &&
			wData_q[`KMS_ST_GHOST_BIT]) begin
			ghost_q <= 1'b0;
		end
	end

	// sticky overflow, set wins over clear
	always_ff @(posedge clk) begin
		if (rst) begin
			ovf_q <= 1'b0;
		end else if (push && full) begin
			ovf_q <= 1'b1;
		end else if (doWrite && awAddr_q == `KMS_OFS_STATUS && wStrb_q[0] &&
			wData_q[`KMS_ST_OVF_BIT]) begin
			ovf_q <= 1'b0;
		end
	end

	assign s_axi_awready = !awHeld_q && !bvalid_q;
	assign s_axi_wready = !wHeld_q && !bvalid_q;
	assign doWrite = awHeld_q && wHeld_q && !bvalid_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= '0;
			wData_q <= '0;
			wStrb_q <= '0;
		end else if (doWrite) begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			bvalid_q <= 1'b0;
			bresp_q <= `KMS_RESP_OKAY;
		end else if (doWrite) begin
			bvalid_q <= 1'b1;
			bresp_q <= isMapped(awAddr_q) ? `KMS_RESP_OKAY : `KMS_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q <= `KMS_CTRL_RST;
			modCode_q <= `KMS_MODCODE_RST;
		end else if (doWrite && awAddr_q == `KMS_OFS_CTRL) begin
			ctrl_q <= applyStrb(ctrl_q, wData_q, wStrb_q);
		end else if (doWrite && awAddr_q == `KMS_OFS_MODCODE) begin
			modCode_q <= applyStrb(modCode_q, wData_q, wStrb_q);
		end
	end

	always_comb begin
		rdMux = 32'h0000_0000;
		case (s_axi_araddr)
			`KMS_OFS_CTRL: rdMux = ctrl_q;
			`KMS_OFS_STATUS: begin
				rdMux[`KMS_ST_GHOST_BIT] = ghost_q;
				rdMux[`KMS_ST_OVF_BIT] = ovf_q;
				rdMux[`KMS_ST_AVAIL_BIT] = avail != '0;
				rdMux[`KMS_ST_COUNT_LSB +: 5] = 5'(avail);
				rdMux[`KMS_ST_CLKREQ_BIT] = clkReq;
				rdMux[`KMS_ST_STATE_LSB +: 2] = state_q;
			end
			`KMS_OFS_KEYDATA: begin
				if (avail != '0) begin
					rdMux[8:0] = headData;
					rdMux[`KMS_KD_VALID_BIT] = 1'b1;
				end
			end
			`KMS_OFS_MODCODE: rdMux = modCode_q;
			`KMS_OFS_MODSTATE: rdMux[3:0] = modState_q;
			`KMS_OFS_DEBUG: rdMux = {8'h00, 8'(rowHit_q), 8'(colIdx_q), keyIdx_q};
			default: rdMux = 32'h0000_0000;
		endcase
	end

	assign s_axi_arready = !rvalid_q;
	assign arTake = s_axi_arvalid && !rvalid_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= `KMS_RESP_OKAY;
		end else if (arTake) begin
			rvalid_q <= 1'b1;
			rdata_q <= rdMux;
			rresp_q <= isMapped(s_axi_araddr) ? `KMS_RESP_OKAY : `KMS_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

endmodule

//--- pkg/kms_cfg.svh
`ifndef KMS_CFG_SVH
`define KMS_CFG_SVH

// Register byte offsets
`define KMS_OFS_CTRL 8'h00
`define KMS_OFS_STATUS 8'h04
`define KMS_OFS_KEYDATA 8'h08
`define KMS_OFS_MODCODE 8'h0c
`define KMS_OFS_MODSTATE 8'h10
`define KMS_OFS_DEBUG 8'h14

// Control fields
`define KMS_CTRL_EN_BIT 0
`define KMS_CTRL_COLS_LSB 8
`define KMS_CTRL_ROWS_LSB 16
`define KMS_CTRL_RST 32'h0008_1400
`define KMS_MODCODE_RST 32'hffff_ffff

// Status fields
`define KMS_ST_GHOST_BIT 0
`define KMS_ST_OVF_BIT 1
`define KMS_ST_AVAIL_BIT 2
`define KMS_ST_COUNT_LSB 3
`define KMS_ST_CLKREQ_BIT 8
`define KMS_ST_STATE_LSB 9

// Key data fields
`define KMS_KD_RELEASE_BIT 8
`define KMS_KD_VALID_BIT 31

// Matrix limits
`define KMS_MAX_COLS 20
`define KMS_MAX_ROWS 8
`define KMS_FIFO_DEPTH 16

// Timing
`define KMS_CLK_HZ 100000000
`define KMS_SCAN_HZ 128000
`define KMS_TICK_CYC (`KMS_CLK_HZ / `KMS_SCAN_HZ)
`define KMS_FILT_TAPS 3

// Bus answers
`define KMS_RESP_OKAY 2'b00
`define KMS_RESP_SLVERR 2'b10

`endif

//--- pkg/kms_pkg.sv
package kms_pkg;

	typedef enum logic [1:0] {
		KMS_IDLE = 2'b00,
		KMS_SCAN = 2'b01,
		KMS_SCAN_END = 2'b11
	} kms_state_type;

	typedef logic [7:0] kms_key_idx_type;

endpackage

//--- verification/kms_key_matrix_scanner_chk.sv
`timescale 1ns/1ps
module kms_key_matrix_scanner_chk #(
	parameter int NUM_COLS = 20
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NUM_COLS-1:0] colDrive,
	input wire logic clkReq
);
	localparam logic [NUM_COLS-1:0] ALL = {NUM_COLS{1'b1}};
	localparam logic [NUM_COLS-1:0] FIRST = {{(NUM_COLS-1){1'b0}}, 1'b1};
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// Column drive lags the state by one cycle, hence three idle samples
	chk_idle_cols_high: assert property ((!clkReq)[*3] |-> colDrive == ALL)
		else $error("columns not all high while idle");
	chk_scan_one_col: assert property (clkReq |-> $onehot(colDrive) || colDrive == ALL)
		else $error("more than one column driven");
	chk_scan_first_col: assert property ($rose(clkReq) |-> ##[1:2] colDrive == FIRST)
		else $error("scan did not start at first column");
	chk_drop_cols_high: assert property ($fell(clkReq) |-> ##[1:2] colDrive == ALL)
		else $error("columns not released after request drop");
	chk_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
		else $error("read answer late");
	chk_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	chk_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	chk_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while answer pending");
endmodule
bind kms_key_matrix_scanner kms_key_matrix_scanner_chk #(.NUM_COLS(NUM_COLS)) u_chk (.clk, .rst,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.colDrive, .clkReq);

//--- verification/kms_matrix_model.sv
`timescale 1ns/1ps
module kms_matrix_model (
	input wire logic [19:0] colDrive,
	input wire logic [159:0] keyDown,
	output logic [7:0] rowIn
);
	// Rows pulled low; a closed switch passes its column level
	always_comb begin
		rowIn = 8'h00;
		for (int c = 0; c < 20; c++) begin
			for (int r = 0; r < 8; r++) begin
				if (keyDown[c*8+r] && colDrive[c]) begin
					rowIn[r] = 1'b1;
				end
			end
		end
	end
endmodule

//--- verification/testbench.sv
`timescale 1ns/1ps
`include "kms_cfg.svh"
`define KMS_CHK(got, exp) begin \
	checkCount++; \
	if ((got) !== (exp)) begin \
		failures++; \
		$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
	end \
end
module testbench;
	logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, clkReq;
	logic [7:0] s_axi_awaddr, s_axi_araddr, rowIn;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [19:0] colDrive;
	logic [159:0] keyDown;
	int failures = 0;
	int checkCount = 0;
	int cycles = 0;
	kms_key_matrix_scanner #(.TICK_CYC(4)) u_dut (.*);
	kms_matrix_model u_keys (.colDrive(colDrive), .keyDown(keyDown), .rowIn(rowIn));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic tally_and_finish();
		$display("checks=%0d failures=%0d", checkCount, failures);
		if (failures == 0 && checkCount > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Generous ceiling; the whole run needs about 10k cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			failures++;
			tally_and_finish();
		end
	end
	task automatic axWr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, b;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge clk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge clk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask
	task automatic axRd(input logic [7:0] a, output logic [31:0] d);
		logic ar, r;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		r = 1'b0;
		while (!r) begin
			@(negedge clk);
			ar = s_axi_arvalid && s_axi_arready;
			r = s_axi_rvalid;
			d = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge clk);
			if (ar) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask
	function automatic logic [31:0] ctrl(input int c, input int r);
		return 32'h1 | (c << 8) | (r << 16);
	endfunction
	task automatic waitReq(input logic lvl);
		for (int n = 0; n < 5000 && clkReq !== lvl; n++) @(negedge clk);
		repeat (2) @(posedge clk);
	endtask
	task automatic waitAvail();
		logic [31:0] s;
		s = 32'h0;
		for (int i = 0; i < 300 && !s[2]; i++) axRd(`KMS_OFS_STATUS, s);
	endtask
	task automatic drain();
		logic [31:0] d;
		d = 32'h8000_0000;
		for (int i = 0; i < 40 && d[31]; i++) axRd(`KMS_OFS_KEYDATA, d);
	endtask
	task automatic t_reset();
		logic [31:0] d;
		axRd(`KMS_OFS_CTRL, d);
		`KMS_CHK(d, `KMS_CTRL_RST)
		axRd(`KMS_OFS_MODCODE, d);
		`KMS_CHK(d, `KMS_MODCODE_RST)
		axRd(8'h18, d);
		`KMS_CHK({rsp, d}, {`KMS_RESP_SLVERR, 32'h0})
		axWr(8'h18, 32'hffff_ffff);
		`KMS_CHK(rsp, `KMS_RESP_SLVERR)
		axWr(`KMS_OFS_STATUS, 32'h0);
		`KMS_CHK(rsp, `KMS_RESP_OKAY)
		keyDown <= 160'h1;
		repeat (60) @(posedge clk);
		`KMS_CHK(clkReq, 1'b0)
		`KMS_CHK(colDrive, 20'hfffff)
		keyDown <= '0;
	endtask
	task automatic t_key();
		logic [31:0] d;
		logic [19:0] seen;
		seen = '0;
		axWr(`KMS_OFS_CTRL, ctrl(4, 3));
		keyDown <= 160'h1 << 10;
		waitReq(1'b1);
		`KMS_CHK(clkReq, 1'b1)
		for (int i = 0; i < 300; i++) begin
			@(negedge clk);
			if (colDrive != 20'hfffff) seen = seen | colDrive;
		end
		`KMS_CHK(seen, 20'h0000f)
		waitAvail();
		axRd(`KMS_OFS_KEYDATA, d);
		`KMS_CHK(d, 32'h8000_0005)
		keyDown <= '0;
		waitAvail();
		axRd(`KMS_OFS_KEYDATA, d);
		`KMS_CHK(d, 32'h8000_0105)
		waitReq(1'b0);
		`KMS_CHK({clkReq, colDrive}, {1'b0, 20'hfffff})
		axRd(`KMS_OFS_KEYDATA, d);
		`KMS_CHK(d, 32'h0)
	endtask
	task automatic t_mod();
		logic [31:0] d;
		axWr(`KMS_OFS_MODCODE, 32'hffff_ff05);
		keyDown <= 160'h1 << 10;
		repeat (800) @(posedge clk);
		axRd(`KMS_OFS_MODSTATE, d);
		`KMS_CHK(d[3:0], 4'h1)
		axRd(`KMS_OFS_STATUS, d);
		`KMS_CHK(d[2], 1'b0)
		keyDown <= '0;
		waitReq(1'b0);
		axWr(`KMS_OFS_MODCODE, 32'hffff_ffff);
		drain();
	endtask
	task automatic t_ghost();
		logic [31:0] d;
		axWr(`KMS_OFS_CTRL, ctrl(3, 2));
		keyDown <= 160'h103;
		repeat (800) @(posedge clk);
		axRd(`KMS_OFS_STATUS, d);
		`KMS_CHK({d[7:3], d[0]}, 6'b00010_1)
		for (int i = 0; i < 2; i++) begin
			axRd(`KMS_OFS_KEYDATA, d);
			`KMS_CHK(d, 32'h8000_0000 | i)
		end
		keyDown <= '0;
		waitReq(1'b0);
		drain();
		axWr(`KMS_OFS_STATUS, 32'h1);
		axRd(`KMS_OFS_STATUS, d);
		`KMS_CHK(d[0], 1'b0)
	endtask
	task automatic t_ovf();
		logic [31:0] d;
		logic [159:0] k;
		k = '0;
		// One key per column keeps the row-hit register clear
		for (int c = 0; c < 17; c++) k[c*8+c%8] = 1'b1;
		axWr(`KMS_OFS_CTRL, ctrl(20, 8));
		keyDown <= k;
		repeat (5000) @(posedge clk);
		axRd(`KMS_OFS_STATUS, d);
		`KMS_CHK(d[7:1], {5'd16, 2'b11})
		axRd(`KMS_OFS_KEYDATA, d);
		`KMS_CHK(d, 32'h8000_0000)
		keyDown <= '0;
		waitReq(1'b0);
		drain();
		axRd(`KMS_OFS_STATUS, d);
		`KMS_CHK(d[2:1], 2'b01)
		axWr(`KMS_OFS_STATUS, 32'h3);
		axRd(`KMS_OFS_STATUS, d);
		`KMS_CHK(d[1:0], 2'b00)
	endtask
	initial begin
		rst = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hf;
		keyDown = '0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_key();
		t_mod();
		t_ghost();
		t_ovf();
		tally_and_finish();
	end
endmodule
